// ===== core/fsc_top.sv
// Purpose: Sticky fault cause flags and fault address capture, on a Wishbone slave.
// Assumes: Fault event inputs are one-cycle pulses from core logic on sys_clk_i.
// Notes: Offsets 0x0 status, 0x4 hard status, 0x8/0xc addresses, 0x10 trap control.
`default_nettype none
module fsc_top
    import fsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic ev_ibus_prefetch_i,
    input wire logic ev_issue_i,
    input wire logic ev_div_zero_i,
    input wire logic ev_unaligned_i,
    input wire logic ev_unaligned_multi_i,
    input wire logic ev_coproc_i,
    input wire logic ev_bad_pc_i,
    input wire logic ev_bad_state_i,
    input wire logic ev_undef_i,
    input wire logic ev_forced_i,
    input wire logic ev_vector_i,
    input wire logic ev_mem_fault_i,
    input wire logic [31:0] ev_mem_addr_i,
    input wire logic ev_bus_precise_i,
    input wire logic [31:0] ev_bus_addr_i,
    output logic div_trap_en_o,
    output logic unal_trap_en_o
);
    logic rst_sync1_ff;
    logic rst_n;
    logic [31:0] cfs_ff;
    logic [31:0] hfs_ff;
    logic [31:0] mfa_ff;
    logic [31:0] bfa_ff;
    logic [31:0] ccr_ff;
    logic ibus_pend_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] dat_ff;

    // Reset is released through two flip-flops.
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_sync1_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_sync1_ff <= 1'b1;
            rst_n <= rst_sync1_ff;
        end
    end

    // Bus decode: a request is accepted once; the ack blocks a second take.
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    wire a_cfs = (wb_adr_i == FSC_OFF_CFS);
    wire a_hfs = (wb_adr_i == FSC_OFF_HFS);
    wire a_mfa = (wb_adr_i == FSC_OFF_MFA);
    wire a_bfa = (wb_adr_i == FSC_OFF_BFA);
    wire a_ccr = (wb_adr_i == FSC_OFF_CCR);
    wire hit = a_cfs | a_hfs | a_mfa | a_bfa | a_ccr;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // A write lands at the edge where the master samples ack, while the request still stands.
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & hit;
    wire [31:0] w1c = wb_dat_i & bmask;

    // Event qualification.
    wire div_hit = ev_div_zero_i & ccr_ff[FSC_CCR_DIV0];
    wire unal_hit = (ev_unaligned_i & ccr_ff[FSC_CCR_UNAL]) | ev_unaligned_multi_i;
    wire ibus_set = ibus_pend_ff & ev_issue_i;

    wire [31:0] cfs_set = (32'(div_hit) << FSC_UF_DIV0)
        | (32'(unal_hit) << FSC_UF_UNAL)
        | (32'(ev_coproc_i) << FSC_UF_NO_COPROC_FLAG)
        | (32'(ev_bad_pc_i) << FSC_UF_PC)
        | (32'(ev_bad_state_i & ~ev_undef_i) << FSC_UF_STATE)
        | (32'(ev_undef_i) << FSC_UF_UNDEF)
        | (32'(ibus_set) << FSC_BF_IBUS)
        | (32'(ev_bus_precise_i) << FSC_BF_PRECISE)
        | (32'(ev_bus_precise_i) << FSC_BF_VALID)
        | (32'(ev_mem_fault_i) << FSC_MF_VALID);
    // A memory fault without a new bus address drops the bus valid flag.
    wire [31:0] cfs_kill = 32'(ev_mem_fault_i & ~ev_bus_precise_i) << FSC_BF_VALID;
    wire [31:0] cfs_clr = (wr & a_cfs) ? w1c : 32'h0000_0000;
    // Set wins over a same-cycle clear.
    wire [31:0] nxt_cfs = ((cfs_ff & ~cfs_clr & ~cfs_kill) | cfs_set) & FSC_CFS_MASK;

    wire [31:0] hfs_set = (32'(ev_forced_i) << FSC_HF_FORCED)
        | (32'(ev_vector_i) << FSC_HF_VECT);
    // Writes cannot clear the debug bit; nothing sets it either, so it stays zero.
    wire [31:0] hfs_clr = (wr & a_hfs) ? (w1c & ~(32'h1 << FSC_HF_DBG)) : 32'h0000_0000;
    wire [31:0] nxt_hfs = ((hfs_ff & ~hfs_clr) | hfs_set) & FSC_HFS_MASK;

    wire [31:0] nxt_mfa = ev_mem_fault_i ? ev_mem_addr_i
        : ((wr & a_mfa) ? ((mfa_ff & ~bmask) | w1c) : mfa_ff);
    // Bus address: requested address on precise error only; fetch errors never load it.
    wire [31:0] nxt_bfa = ev_bus_precise_i ? ev_bus_addr_i
        : ((wr & a_bfa) ? ((bfa_ff & ~bmask) | w1c) : bfa_ff);

    // Read selection; the trap control word is the fifth mapped register.
    wire [31:0] rd_mux = a_cfs ? cfs_ff : a_hfs ? hfs_ff : a_mfa ? mfa_ff : a_bfa ? bfa_ff
        : a_ccr ? ccr_ff : 32'h0000_0000;

    // Status registers and fetch-error pending marker.
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfs_ff <= FSC_RST_WORD;
            hfs_ff <= FSC_RST_WORD;
            mfa_ff <= FSC_RST_WORD;
            bfa_ff <= FSC_RST_WORD;
            ibus_pend_ff <= 1'b0;
        end
        else
        begin
            cfs_ff <= nxt_cfs;
            hfs_ff <= nxt_hfs;
            mfa_ff <= nxt_mfa;
            bfa_ff <= nxt_bfa;
            ibus_pend_ff <= (ibus_pend_ff | ev_ibus_prefetch_i) & ~ev_issue_i;
        end
    end

    // Trap control register, written by byte lane; its enables gate the divide and single unaligned traps, not unaligned multiple.
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ccr_ff <= FSC_RST_WORD;
        else if (wr & a_ccr)
            ccr_ff <= (ccr_ff & ~bmask) | w1c;
    end

    // Bus answer registered one cycle after the request; unmapped gives err.
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= FSC_RST_WORD;
            div_trap_en_o <= 1'b0;
            unal_trap_en_o <= 1'b0;
        end
        else
        begin
            ack_ff <= req & hit;
            err_ff <= req & ~hit;
            dat_ff <= rd_mux;
            div_trap_en_o <= ccr_ff[FSC_CCR_DIV0];
            unal_trap_en_o <= ccr_ff[FSC_CCR_UNAL];
        end
    end

    // Bus outputs come straight from their flip-flops.
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = dat_ff;

    a_div_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_div_zero_i && !ccr_ff[FSC_CCR_DIV0] && !cfs_ff[FSC_UF_DIV0]) |=> !cfs_ff[FSC_UF_DIV0])
        else $error("zero divide flag set without trap enable");
    a_unal_multi: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ev_unaligned_multi_i |=> cfs_ff[FSC_UF_UNAL])
        else $error("unaligned multiple did not set flag");
    a_uf_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (cfs_ff[FSC_UF_UNDEF] && !(wr && a_cfs && wb_dat_i[FSC_UF_UNDEF] && wb_sel_i[2])) |=> cfs_ff[FSC_UF_UNDEF])
        else $error("usage flag lost without clear");
    a_hf_forced: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ev_forced_i |=> hfs_ff[FSC_HF_FORCED])
        else $error("forced bit not set");
    a_bfa_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ev_bus_precise_i |=> (bfa_ff == $past(ev_bus_addr_i)) && cfs_ff[FSC_BF_VALID])
        else $error("bus fault address not captured");

    // An issue with no pending prefetch error must not raise the fetch error flag.
    a_ibus_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_issue_i && !ibus_pend_ff && !cfs_ff[FSC_BF_IBUS] && !(wr && a_cfs)) |=> !cfs_ff[FSC_BF_IBUS])
        else $error("fetch error flag set without pending error");

    // A prefetch error followed by issue must raise the fetch error flag.
    a_ibus_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_issue_i && ibus_pend_ff) |=> cfs_ff[FSC_BF_IBUS])
        else $error("fetch error flag not set on issue");

    // A memory fault loads its address and marks it valid.
    a_mfa_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ev_mem_fault_i |=> (mfa_ff == $past(ev_mem_addr_i)) && cfs_ff[FSC_MF_VALID])
        else $error("memory fault address not captured");

    // A memory fault with no new bus address drops the bus valid flag.
    a_bfv_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_mem_fault_i && !ev_bus_precise_i) |=> !cfs_ff[FSC_BF_VALID])
        else $error("bus valid flag kept after memory fault");

    // Coprocessor, bad PC load and undecodable op each set their own flag.
    a_uf_causes: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_coproc_i || ev_bad_pc_i || ev_undef_i)
        |=> ((cfs_ff[FSC_UF_NO_COPROC_FLAG] || !$past(ev_coproc_i)) && (cfs_ff[FSC_UF_PC] || !$past(ev_bad_pc_i))
        && (cfs_ff[FSC_UF_UNDEF] || !$past(ev_undef_i))))
        else $error("usage cause flag not set");

    // An undefined instruction touching the status word must not set the bad state flag.
    a_state_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (ev_bad_state_i && ev_undef_i && !cfs_ff[FSC_UF_STATE]) |=> !cfs_ff[FSC_UF_STATE])
        else $error("bad state flag set by undefined instruction");

    // Vector read faults set their hard fault bit.
    a_hf_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ev_vector_i |=> hfs_ff[FSC_HF_VECT])
        else $error("vector read bit not set");

    // The vector read bit survives anything but a write of one to it.
    a_hf_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (hfs_ff[FSC_HF_VECT] && !(wr && a_hfs && wb_dat_i[FSC_HF_VECT] && wb_sel_i[0])) |=> hfs_ff[FSC_HF_VECT])
        else $error("hard fault bit lost without clear");

    // The answer stands for exactly one cycle.
    a_ack_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
endmodule // fsc_top
`default_nettype wire

// ===== core/fsc_pkg.sv
// Purpose: Constants for the fault status capture block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes: Register offsets are local to this block.
`default_nettype none
package fsc_pkg;
    // Five word registers need a 5-bit byte address; trap control sits at the fifth word.
    localparam logic [4:0] FSC_OFF_CFS = 5'h00;
    localparam logic [4:0] FSC_OFF_HFS = 5'h04;
    localparam logic [4:0] FSC_OFF_MFA = 5'h08;
    localparam logic [4:0] FSC_OFF_BFA = 5'h0c;
    localparam logic [4:0] FSC_OFF_CCR = 5'h10;
    localparam int FSC_UF_UNDEF = 16;
    localparam int FSC_UF_STATE = 17;
    localparam int FSC_UF_PC = 18;
    localparam int FSC_UF_NO_COPROC_FLAG = 19;
    localparam int FSC_UF_UNAL = 24;
    localparam int FSC_UF_DIV0 = 25;
    localparam int FSC_BF_IBUS = 8;
    localparam int FSC_BF_PRECISE = 9;
    localparam int FSC_BF_VALID = 15;
    localparam int FSC_MF_VALID = 7;
    localparam int FSC_HF_VECT = 1;
    localparam int FSC_HF_FORCED = 30;
    localparam int FSC_HF_DBG = 31;
    localparam int FSC_CCR_UNAL = 3;
    localparam int FSC_CCR_DIV0 = 4;
    localparam logic [31:0] FSC_CFS_MASK = 32'h030f_8380;
    localparam logic [31:0] FSC_HFS_MASK = 32'hc000_0002;
    localparam logic [31:0] FSC_RST_WORD = 32'h0000_0000;
endpackage : fsc_pkg
`default_nettype wire

// ===== verif/fsc_top_bench.sv
// Purpose: Self-checking bench for the fault status capture block.
// Assumes: Classic Wishbone slave answering one cycle after a request.
// Notes: Fault events are one-cycle pulses; trap enables are switched on and off again through the trap control register.
`default_nettype none
module fsc_top_bench
    import fsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [12:0] ev = 13'h0;
    logic [31:0] maddr = 32'h0;
    logic [31:0] baddr = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic err;
    logic div_en;
    logic unal_en;
    logic [31:0] q;
    int err_count = 0;
    int check_count = 0;
    int evs[5] = '{5, 6, 7, 8, 4};
    int bits[5] = '{FSC_UF_NO_COPROC_FLAG, FSC_UF_PC, FSC_UF_STATE, FSC_UF_UNDEF, FSC_UF_UNAL};

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    fsc_top u_fsc_top (.sys_clk_i(clk), .resetn_i(resetn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .ev_ibus_prefetch_i(ev[0]), .ev_issue_i(ev[1]), .ev_div_zero_i(ev[2]), .ev_unaligned_i(ev[3]),
        .ev_unaligned_multi_i(ev[4]), .ev_coproc_i(ev[5]), .ev_bad_pc_i(ev[6]), .ev_bad_state_i(ev[7]),
        .ev_undef_i(ev[8]), .ev_forced_i(ev[9]), .ev_vector_i(ev[10]), .ev_mem_fault_i(ev[11]),
        .ev_mem_addr_i(maddr), .ev_bus_precise_i(ev[12]), .ev_bus_addr_i(baddr),
        .div_trap_en_o(div_en), .unal_trap_en_o(unal_en));

    // Compares one 32-bit result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle, held until ack or err is sampled high.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        // Answers are looked at mid-cycle, where they have settled.
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        q = dat_o;
        // The rising edge at which ack stands high; only then is the request released.
        @(posedge clk);
        if (n >= 50) err_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(q, exp);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s);
    endtask

    // Raises one event line for a single cycle.
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 13'h1 << k;
        @(posedge clk);
        ev <= 13'h0;
        @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hang short; the tests need well under a thousand cycles.
    initial
    begin
        #100000;
        err_count++;
        wrap_up();
    end

    // Main test sequence.
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'h0, div_en, unal_en}, 32'h0);
        rd(FSC_OFF_CFS, FSC_RST_WORD);
        rd(FSC_OFF_HFS, FSC_RST_WORD);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            pulse(evs[i]);
            rd(FSC_OFF_CFS, 32'h1 << bits[i]);
            wr(FSC_OFF_CFS, 32'h0, 4'hf);
            rd(FSC_OFF_CFS, 32'h1 << bits[i]);
            wr(FSC_OFF_CFS, 32'h1 << bits[i], 4'hf);
            rd(FSC_OFF_CFS, 32'h0);
        end
        pulse(2);
        pulse(3);
        rd(FSC_OFF_CFS, 32'h0);
        wr(FSC_OFF_CCR, 32'h0000_0018, 4'hf);
        rd(FSC_OFF_CCR, 32'h0000_0018);
        chk({30'h0, div_en, unal_en}, 32'h3);
        pulse(2);
        pulse(3);
        rd(FSC_OFF_CFS, (32'h1 << FSC_UF_DIV0) | (32'h1 << FSC_UF_UNAL));
        wr(FSC_OFF_CFS, 32'h0300_0000, 4'hf);
        wr(FSC_OFF_CCR, 32'h0, 4'hf);
        rd(FSC_OFF_CFS, 32'h0);
        pulse(0);
        rd(FSC_OFF_CFS, 32'h0);
        pulse(1);
        rd(FSC_OFF_CFS, 32'h1 << FSC_BF_IBUS);
        rd(FSC_OFF_BFA, 32'h0);
        wr(FSC_OFF_CFS, 32'h1 << FSC_BF_IBUS, 4'hf);
        $display("test usage flags done");
        pulse(9);
        pulse(10);
        rd(FSC_OFF_HFS, 32'h4000_0002);
        wr(FSC_OFF_HFS, 32'h0000_0002, 4'hf);
        rd(FSC_OFF_HFS, 32'h4000_0000);
        wr(FSC_OFF_HFS, 32'h0, 4'hf);
        rd(FSC_OFF_HFS, 32'h4000_0000);
        wr(FSC_OFF_HFS, 32'h4000_0000, 4'hf);
        rd(FSC_OFF_HFS, 32'h0);
        $display("test hard status done");
        baddr <= 32'h2000_0013;
        pulse(12);
        rd(FSC_OFF_BFA, 32'h2000_0013);
        rd(FSC_OFF_CFS, (32'h1 << FSC_BF_PRECISE) | (32'h1 << FSC_BF_VALID));
        maddr <= 32'h1000_0042;
        pulse(11);
        rd(FSC_OFF_MFA, 32'h1000_0042);
        rd(FSC_OFF_CFS, (32'h1 << FSC_BF_PRECISE) | (32'h1 << FSC_MF_VALID));
        wr(FSC_OFF_CFS, 32'hffff_ffff, 4'h2);
        rd(FSC_OFF_CFS, 32'h1 << FSC_MF_VALID);
        $display("test fault address done");
        pulse(5);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(FSC_OFF_CFS, FSC_RST_WORD);
        rd(FSC_OFF_MFA, FSC_RST_WORD);
        $display("test mid reset done");
        wrap_up();
    end
endmodule // fsc_top_bench
`default_nettype wire
